// file: verilog/mmd_decoder.sv
// Memory map decoder: fetch and data-move routing, registers, data SRAM
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module mmd_decoder
    import mmd_pkg::*;
(
    input wire logic mclk, // Core clock, 20 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [7:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Register write data
    input wire logic regWr, // Register write strobe
    input wire logic regRd, // Register read strobe
    output logic [7:0] regRdata, // Register read data, cycle after read
    input wire logic fetchReq, // Instruction fetch request
    input wire logic [15:0] fetchAddr, // Fetch address
    input wire logic [7:0] romData, // On-chip ROM data for this fetch
    output logic [7:0] fetchData, // Fetched byte, for requests with the bus idle: cycle after on-chip request or after external data phase
    output logic fetchValid, // Fetched byte valid
    input wire logic dmReq, // Data move request
    input wire logic dmWrite, // Data move is a write
    input wire logic [15:0] dmAddr, // Data move address
    input wire logic [7:0] dmWdata, // Data move write data
    output logic [7:0] dmRdata, // Data move read data
    output logic dmValid, // Data move done
    input wire logic extFetchForce_n, // Low forces external fetch
    input wire logic [2:0] securityLockBits, // Programmed lock bits
    output logic [7:0] lowAddrDataOut, // Low address/data port out
    output logic lowAddrDataOe, // Low address/data port enable
    input wire logic [7:0] lowAddrDataIn, // Low address/data port in
    output logic [7:0] highAddrPort, // High address byte
    output logic busActive, // Ports serve as bus, not I/O
    output logic progFetchStrobe_n, // Program fetch strobe, active low
    output logic dataRd_n, // External data read strobe
    output logic dataWr_n // External data write strobe
);
    typedef enum logic [2:0] {
        MMD_IDLE = 3'b001,
        MMD_ADDR = 3'b010,
        MMD_DATA = 3'b100
    } mmd_bus_e;

    logic [2:0] romLimit_q;
    logic [5:0] pmrUpper_q;
    logic [1:0] dataMap_q;
    logic taKey_q;
    logic [2:0] taOpen_q;
    logic [7:0] sram [0:SRAM_WORDS-1];
    logic fetchExt;
    logic taOpen;
    mmd_bus_e busState_q;
    logic busIsFetch_q;
    logic busIsWrite_q;
    logic [15:0] busAddr_q;
    logic [7:0] busWdata_q;

    assign taOpen = (taOpen_q != 3'h0);

    // Combinational decode so a freshly written limit rules the next fetch
    mmd_rom_limit uLimit (
        .limitSel(romLimit_q),
        .fetchAddr(fetchAddr),
        .extFetchForce_n(extFetchForce_n),
        .fetchExternal(fetchExt)
    );

    // Timed-access unlock: two keys open a short write window
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            taKey_q <= 1'b0;
            taOpen_q <= 3'h0;
        end else if (regWr && regAddr == TIMED_ACC_OFFS) begin
            taKey_q <= (regWdata == TA_KEY1);
            taOpen_q <= (taKey_q && regWdata == TA_KEY2) ?
                TA_WINDOW_CYCLES : 3'h0;
        end else begin
            if (taOpen) begin
                taOpen_q <= taOpen_q - 3'h1;
            end
            if (regWr) begin
                taKey_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            romLimit_q <= ROM_LIMIT_RESET;
        end else if (regWr && regAddr == ROM_LIMIT_OFFS && taOpen) begin
            romLimit_q <= regWdata[ROM_SEL_LSB+:3];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dataMap_q <= DATA_MAP_RESET;
            pmrUpper_q <= PMR_UPPER_RESET;
        end else if (regWr && regAddr == POWER_MGMT_OFFS) begin
            dataMap_q <= regWdata[DATA_MAP_LSB+:2];
            pmrUpper_q <= regWdata[7:2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                ROM_LIMIT_OFFS: regRdata <= {5'h00, romLimit_q};
                POWER_MGMT_OFFS: regRdata <= {pmrUpper_q, dataMap_q};
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // Data SRAM: only data moves reach it; no reset so map changes keep it
    logic dmInt;
    logic dmLock;
    logic dmExt;
    assign dmInt = dmReq && (dmAddr <= SRAM_TOP)
        && (dataMap_q == DMAP_INT || dataMap_q == DMAP_LOCK);
    assign dmLock = dmReq && !dmWrite && dataMap_q == DMAP_LOCK
        && dmAddr == LOCK_ADDR;
    assign dmExt = dmReq && (dataMap_q == DMAP_EXT
        || (dataMap_q == DMAP_INT && dmAddr > SRAM_TOP));

    always_ff @(posedge mclk) begin
        if (dmInt && dmWrite) begin
            sram[dmAddr[SRAM_AW-1:0]] <= dmWdata;
        end
    end

    // Internal and no-access moves answer next cycle; external via bus
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dmRdata <= 8'h00;
            dmValid <= 1'b0;
        end else if (busState_q == MMD_DATA && !busIsFetch_q) begin
            dmRdata <= busIsWrite_q ? 8'h00 : lowAddrDataIn;
            dmValid <= 1'b1;
        end else if (dmReq && !dmExt) begin
            dmValid <= 1'b1;
            if (dmInt && !dmWrite) begin
                dmRdata <= sram[dmAddr[SRAM_AW-1:0]];
            end else if (dmLock) begin
                dmRdata <= {5'h00, securityLockBits};
            end else begin
                dmRdata <= 8'h00;
            end
        end else begin
            dmValid <= 1'b0;
        end
    end

    // External bus: address phase then data phase
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busState_q <= MMD_IDLE;
            busIsFetch_q <= 1'b0;
            busIsWrite_q <= 1'b0;
            busAddr_q <= 16'h0000;
            busWdata_q <= 8'h00;
        end else begin
            unique case (busState_q)
                MMD_IDLE: begin
                    if (fetchReq && fetchExt) begin
                        busState_q <= MMD_ADDR;
                        busIsFetch_q <= 1'b1;
                        busIsWrite_q <= 1'b0;
                        busAddr_q <= fetchAddr;
                    end else if (dmExt) begin
                        busState_q <= MMD_ADDR;
                        busIsFetch_q <= 1'b0;
                        busIsWrite_q <= dmWrite;
                        busAddr_q <= dmAddr;
                        busWdata_q <= dmWdata;
                    end
                end
                MMD_ADDR: busState_q <= MMD_DATA;
                MMD_DATA: busState_q <= MMD_IDLE;
            endcase
        end
    end

    // Pin drivers registered from the next bus state
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lowAddrDataOut <= 8'h00;
            lowAddrDataOe <= 1'b0;
            highAddrPort <= 8'h00;
            busActive <= 1'b0;
            progFetchStrobe_n <= 1'b1;
            dataRd_n <= 1'b1;
            dataWr_n <= 1'b1;
        end else begin
            unique case (busState_q)
                MMD_ADDR: begin
                    busActive <= 1'b1;
                    highAddrPort <= busAddr_q[15:8];
                    lowAddrDataOut <= busIsWrite_q ? busWdata_q : 8'h00;
                    lowAddrDataOe <= busIsWrite_q;
                    progFetchStrobe_n <= !busIsFetch_q;
                    dataRd_n <= busIsFetch_q || busIsWrite_q;
                    dataWr_n <= !busIsWrite_q;
                end
                MMD_IDLE: begin
                    if ((fetchReq && fetchExt) || dmExt) begin
                        busActive <= 1'b1;
                        highAddrPort <= fetchReq && fetchExt ?
                            fetchAddr[15:8] : dmAddr[15:8];
                        lowAddrDataOut <= fetchReq && fetchExt ?
                            fetchAddr[7:0] : dmAddr[7:0];
                        lowAddrDataOe <= 1'b1;
                    end else begin
                        busActive <= 1'b0;
                        lowAddrDataOe <= 1'b0;
                    end
                    progFetchStrobe_n <= 1'b1;
                    dataRd_n <= 1'b1;
                    dataWr_n <= 1'b1;
                end
                default: begin
                    busActive <= 1'b0;
                    lowAddrDataOe <= 1'b0;
                    progFetchStrobe_n <= 1'b1;
                    dataRd_n <= 1'b1;
                    dataWr_n <= 1'b1;
                end
            endcase
        end
    end

    // Fetch answer, only for requests with the bus idle: on-chip next cycle, external after data phase
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fetchData <= 8'h00;
            fetchValid <= 1'b0;
        end else if (busState_q == MMD_DATA && busIsFetch_q) begin
            fetchData <= lowAddrDataIn;
            fetchValid <= 1'b1;
        end else if (fetchReq && !fetchExt && busState_q == MMD_IDLE) begin
            fetchData <= romData;
            fetchValid <= 1'b1;
        end else begin
            fetchValid <= 1'b0;
        end
    end

    chk_limit_reset: assert property (@(posedge mclk)
        $rose(rst_b) |-> romLimit_q == ROM_LIMIT_RESET)
        else $error("rom limit not 16 kB after reset");
    chk_limit_locked: assert property (@(posedge mclk) disable iff (!rst_b)
        regWr && regAddr == ROM_LIMIT_OFFS && !taOpen
        |=> $stable(romLimit_q))
        else $error("unlocked rom limit write took effect");
    chk_force_ext: assert property (@(posedge mclk) disable iff (!rst_b)
        fetchReq && !extFetchForce_n |-> fetchExt)
        else $error("forced fetch not external");
    chk_fetch_strobe: assert property (@(posedge mclk) disable iff (!rst_b)
        busState_q == MMD_ADDR && busIsFetch_q
        |=> !progFetchStrobe_n ##1 progFetchStrobe_n)
        else $error("fetch strobe not pulsed low");
    chk_map_default: assert property (@(posedge mclk) disable iff (!rst_b)
        dataMap_q == DMAP_EXT |-> !dmInt)
        else $error("sram visible in default map");
    chk_lock_read: assert property (@(posedge mclk) disable iff (!rst_b)
        dmLock && busState_q != MMD_DATA
        |=> dmValid && dmRdata == {5'h00, $past(securityLockBits)})
        else $error("lock byte wrong");
    chk_no_ext_map3: assert property (@(posedge mclk) disable iff (!rst_b)
        dataMap_q == DMAP_LOCK |-> !dmExt)
        else $error("external access in map 11");
    chk_above_sram: assert property (@(posedge mclk) disable iff (!rst_b)
        dmReq && dataMap_q == DMAP_INT && dmAddr > SRAM_TOP
        |-> dmExt)
        else $error("high address not external");
endmodule : mmd_decoder

// file: common/mmd_pkg.sv
// Package with register map, fields and encodings of the memory map decoder
package mmd_pkg;
    localparam logic [7:0] ROM_LIMIT_OFFS = 8'hC2;
    localparam logic [7:0] POWER_MGMT_OFFS = 8'hC4;
    localparam logic [7:0] TIMED_ACC_OFFS = 8'hC7;
    localparam logic [7:0] TA_KEY1 = 8'hAA;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    localparam logic [2:0] TA_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] ROM_LIMIT_RESET = 3'h5;
    localparam logic [1:0] DATA_MAP_RESET = 2'h0;
    localparam logic [5:0] PMR_UPPER_RESET = 6'h00;
    localparam int ROM_SEL_LSB = 0;
    localparam int DATA_MAP_LSB = 0;
    localparam logic [1:0] DMAP_EXT = 2'h0;
    localparam logic [1:0] DMAP_INT = 2'h1;
    localparam logic [1:0] DMAP_LOCK = 2'h3;
    localparam logic [15:0] SRAM_TOP = 16'h03FF;
    localparam logic [15:0] LOCK_ADDR = 16'hFFFC;
    localparam logic [15:0] ROM_TOP = 16'h3FFF;
    localparam int SRAM_WORDS = 1024;
    localparam int SRAM_AW = 10;
endpackage : mmd_pkg

// file: verilog/mmd_rom_limit.sv
// ROM limit selector decoding and fetch routing
`timescale 1ns/1ps
module mmd_rom_limit
    import mmd_pkg::*;
(
    input wire logic [2:0] limitSel, // Current limit selector
    input wire logic [15:0] fetchAddr, // Fetch address
    input wire logic extFetchForce_n, // Low forces external fetch
    output logic fetchExternal // Fetch goes off-chip
);
    function automatic logic [15:0] mmd_limit_top(input logic [2:0] sel);
        unique case (sel)
            3'h1: mmd_limit_top = 16'h03FF;
            3'h2: mmd_limit_top = 16'h07FF;
            3'h3: mmd_limit_top = 16'h0FFF;
            3'h4: mmd_limit_top = 16'h1FFF;
            3'h5: mmd_limit_top = ROM_TOP;
            default: mmd_limit_top = 16'h0000;
        endcase
    endfunction : mmd_limit_top

    logic noOnChip;
    // Code 0 and reserved codes decode no on-chip ROM
    assign noOnChip = (limitSel == 3'h0) || (limitSel > 3'h5);
    assign fetchExternal = !extFetchForce_n || noOnChip
        || (fetchAddr > mmd_limit_top(limitSel));
endmodule : mmd_rom_limit

// file: verif/mmd_ext_mem_model.sv
// Behavioural external program and data memory on the multiplexed bus
`timescale 1ns/1ps
module mmd_ext_mem_model (
    input wire logic mclk, // Core clock
    input wire logic busActive, // Ports serve as bus
    input wire logic [7:0] lowAddrDataOut, // Low address/data from core
    input wire logic lowAddrDataOe, // Core drives low port
    input wire logic [7:0] highAddrPort, // High address byte
    input wire logic progFetchStrobe_n, // Program fetch strobe
    input wire logic dataRd_n, // Data read strobe
    input wire logic dataWr_n, // Data write strobe
    output logic [7:0] lowAddrDataIn, // Low port level seen by core
    output int extCnt // Strobed bus cycles so far
);
    logic [15:0] addrQ = 16'h0000;
    logic [7:0] lastQ = 8'h00;
    logic [7:0] xmem [0:65535];
    logic idle;
    int cntQ = 0;
    assign idle = progFetchStrobe_n & dataRd_n & dataWr_n;
    assign extCnt = cntQ;
    // Address phase: core drives the port while all strobes are idle
    always @(posedge mclk) begin
        if (busActive && lowAddrDataOe && idle)
            addrQ <= {highAddrPort, lowAddrDataOut};
        if (busActive && !idle)
            cntQ <= cntQ + 1;
        if (busActive && !dataWr_n)
            xmem[addrQ] <= lowAddrDataOut;
        lastQ <= lowAddrDataIn;
    end
    // A released port shows a changing pattern, never stale data
    always_comb begin
        if (lowAddrDataOe)
            lowAddrDataIn = lowAddrDataOut;
        else if (!progFetchStrobe_n)
            lowAddrDataIn = addrQ[7:0] ^ addrQ[15:8] ^ 8'h5A;
        else if (!dataRd_n)
            lowAddrDataIn = xmem[addrQ];
        else
            lowAddrDataIn = ~lastQ;
    end
endmodule : mmd_ext_mem_model

// file: verif/memory_map_decoder_tb.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module memory_map_decoder_tb;
    import mmd_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic fetchReq = 1'b0;
    logic dmReq = 1'b0;
    logic dmWrite = 1'b0;
    logic extFetchForce_n = 1'b1;
    logic [2:0] securityLockBits = 3'h0;
    logic [2:0] curSel = ROM_LIMIT_RESET;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] romData = 8'h00;
    logic [7:0] dmWdata = 8'h00;
    logic [15:0] fetchAddr = 16'h0000;
    logic [15:0] dmAddr = 16'h0000;
    logic [7:0] regRdata, fetchData, dmRdata, lowOut, lowIn, highPort;
    logic [7:0] rd, sramVal, lockExp;
    logic [15:0] noExt [4] = '{16'h0400, 16'hFFFB, 16'hFFFD, 16'hFFFF};
    logic fetchValid, dmValid, lowOe, busActive, prog_n, rd_n, wr_n;
    logic [16:0] lim;
    int extCnt;
    int nErrors = 0;
    int checksDone = 0;

    always #25 mclk = ~mclk;

    mmd_decoder DUT (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
        .romData(romData), .fetchData(fetchData), .fetchValid(fetchValid),
        .dmReq(dmReq), .dmWrite(dmWrite), .dmAddr(dmAddr),
        .dmWdata(dmWdata), .dmRdata(dmRdata), .dmValid(dmValid),
        .extFetchForce_n(extFetchForce_n),
        .securityLockBits(securityLockBits), .lowAddrDataOut(lowOut),
        .lowAddrDataOe(lowOe), .lowAddrDataIn(lowIn),
        .highAddrPort(highPort), .busActive(busActive),
        .progFetchStrobe_n(prog_n), .dataRd_n(rd_n), .dataWr_n(wr_n));
    mmd_ext_mem_model extMem (.mclk(mclk), .busActive(busActive),
        .lowAddrDataOut(lowOut), .lowAddrDataOe(lowOe),
        .highAddrPort(highPort), .progFetchStrobe_n(prog_n),
        .dataRd_n(rd_n), .dataWr_n(wr_n), .lowAddrDataIn(lowIn),
        .extCnt(extCnt));

    task automatic print_verdict;
        if (nErrors == 0 && checksDone > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic cmp8(input string what, input logic [7:0] e, g);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp8

    function automatic logic [16:0] limitOf(input logic [2:0] s);
        return (s == 3'h0 || s > 3'h5) ? 17'h00000 : 17'h00200 << s;
    endfunction : limitOf

    // Byte the far-side memory returns for an external program fetch
    function automatic logic [7:0] extByte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : extByte

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
        @(posedge mclk);
    endtask : regRead

    task automatic setLimit(input logic [2:0] s);
        regWrite(TIMED_ACC_OFFS, TA_KEY1);
        regWrite(TIMED_ACC_OFFS, TA_KEY2);
        regWrite(ROM_LIMIT_OFFS, {5'h00, s});
        curSel = s;
    endtask : setLimit

    task automatic doFetch(input logic [15:0] a);
        int k;
        fetchReq <= 1'b1;
        fetchAddr <= a;
        romData <= a[7:0] + a[15:8];
        @(posedge mclk);
        fetchReq <= 1'b0;
        k = 0;
        #1;
        while (fetchValid !== 1'b1 && k < 8) begin
            @(posedge mclk);
            #1;
            k++;
        end
        cmp8("fetchValid", 8'h01, {7'h00, fetchValid});
        if (extFetchForce_n && {1'b0, a} < limitOf(curSel))
            cmp8("fetchData", a[7:0] + a[15:8], fetchData);
        else
            cmp8("fetchData", extByte(a), fetchData);
        @(posedge mclk);
    endtask : doFetch

    task automatic doMove(input logic w, input logic [15:0] a,
        input logic [7:0] d, input logic ext, input logic [7:0] e);
        int k;
        int c0;
        c0 = extCnt;
        dmReq <= 1'b1;
        dmWrite <= w;
        dmAddr <= a;
        dmWdata <= d;
        @(posedge mclk);
        dmReq <= 1'b0;
        k = 0;
        #1;
        while (dmValid !== 1'b1 && k < 8) begin
            @(posedge mclk);
            #1;
            k++;
        end
        cmp8("dmValid", 8'h01, {7'h00, dmValid});
        if (!w)
            cmp8("dmRdata", e, dmRdata);
        @(posedge mclk);
        cmp8("extAccess", {7'h00, ext}, {7'h00, extCnt != c0});
    endtask : doMove

    initial begin
        #250000;
        nErrors++;
        print_verdict;
    end

    initial begin
        void'($urandom(32'h035B6B59));
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        regRead(ROM_LIMIT_OFFS, rd);
        cmp8("romLimit", 8'h05, rd);
        regRead(POWER_MGMT_OFFS, rd);
        cmp8("powerMgmt", 8'h00, rd);
        regRead(8'h00, rd);
        cmp8("unmapped", 8'h00, rd);
        doFetch(16'h3FFF);
        doFetch(16'h4000);
        // Plain write, then a key sequence broken by another write
        regWrite(ROM_LIMIT_OFFS, 8'h02);
        regWrite(TIMED_ACC_OFFS, TA_KEY1);
        regWrite(POWER_MGMT_OFFS, 8'h00);
        regWrite(TIMED_ACC_OFFS, TA_KEY2);
        regWrite(ROM_LIMIT_OFFS, 8'h02);
        regRead(ROM_LIMIT_OFFS, rd);
        cmp8("romLimit", 8'h05, rd);
        for (int s = 0; s < 8; s++) begin
            setLimit(3'(s));
            lim = limitOf(curSel);
            doFetch(lim[15:0]);
            doFetch(lim[15:0] - 16'h0001);
            doFetch(16'($urandom_range(0, 16'h4FFF)));
            regRead(ROM_LIMIT_OFFS, rd);
            cmp8("romLimit", {5'h00, curSel}, rd);
        end
        setLimit(3'h5);
        extFetchForce_n <= 1'b0;
        doFetch(16'h0000);
        extFetchForce_n <= 1'b1;
        sramVal = 8'($urandom);
        lockExp = {5'h00, 3'($urandom)};
        securityLockBits <= lockExp[2:0];
        doMove(1'b1, 16'h03FF, 8'h3C, 1'b1, 8'h00);
        doMove(1'b0, 16'h03FF, 8'h00, 1'b1, 8'h3C);
        regWrite(POWER_MGMT_OFFS, 8'hA5);
        regRead(POWER_MGMT_OFFS, rd);
        cmp8("powerMgmt", 8'hA5, rd);
        doMove(1'b1, 16'h03FF, sramVal, 1'b0, 8'h00);
        doMove(1'b0, 16'h03FF, 8'h00, 1'b0, sramVal);
        doMove(1'b1, 16'h0400, 8'h77, 1'b1, 8'h00);
        doMove(1'b0, 16'h0400, 8'h00, 1'b1, 8'h77);
        regWrite(POWER_MGMT_OFFS, 8'hA4);
        doMove(1'b0, 16'h03FF, 8'h00, 1'b1, 8'h3C);
        regWrite(POWER_MGMT_OFFS, 8'hA7);
        doMove(1'b0, 16'h03FF, 8'h00, 1'b0, sramVal);
        doMove(1'b0, LOCK_ADDR, 8'h00, 1'b0, lockExp);
        doMove(1'b1, LOCK_ADDR, 8'hFF, 1'b0, 8'h00);
        doMove(1'b0, LOCK_ADDR, 8'h00, 1'b0, lockExp);
        foreach (noExt[i]) begin
            doMove(1'b1, noExt[i], 8'h11, 1'b0, 8'h00);
            doMove(1'b0, noExt[i], 8'h00, 1'b0, 8'h00);
        end
        regWrite(POWER_MGMT_OFFS, 8'hA6);
        doMove(1'b0, 16'h0010, 8'h00, 1'b0, 8'h00);
        print_verdict;
    end
endmodule : memory_map_decoder_tb
